// file: src/modem_handshake_consts.vh
// Purpose: shared constants for the modem handshake control block
// Assumes: 125 MHz device clock
// Notes: answer timeout counts are derived from the time in seconds
`ifndef MODEM_HANDSHAKE_CONSTS_VH
`define MODEM_HANDSHAKE_CONSTS_VH

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_HZ 125000000
`define ANSWER_TIMEOUT_S 10
`define ANSWER_TIMEOUT_CYC (`ANSWER_TIMEOUT_S * `CLK_HZ)
`define MAX_BIT_RATE 9600

// ----------------------------------------
// rate select codes (bit rate selection switch)
// ----------------------------------------
`define RATE_SEL_W 3
`define RATE_SEL_MAX 3'h6

`endif

// file: src/modem_handshake_control.v
// Purpose: modem handshake control for the asynchronous serial port
// Assumes: modem status pins are asynchronous and are synchronised here
// Notes: the transmitter and receiver are outside; this block only gates them
`timescale 1ns/1ps
`include "modem_handshake_consts.vh"

// What this block does
// - full duplex keeps request to send asserted
// - half duplex: request to send follows permission
// - no character starts without clear to send
// - clear to send loss pauses sending
// - terminal ready high except during hang-up
// - no transfer while data set ready off
// - receive accepted only with carrier present
// - full duplex also needs carrier to send
// - handshake used when option switch on or in half duplex
// - bit rate selections above 9600 refused
// - half duplex always uses the handshake
// - data set ready starts answer timer
// - timeout drops terminal ready until set-ready off
// - carrier loss restarts timer, hangs up if carrier stays off
module modem_handshake_control
#(
  parameter ANSWER_TIMEOUT_CYCLES = `ANSWER_TIMEOUT_CYC
)
(
  input wire clk_i,
  input wire reset_i,
  input wire half_duplex_i,
  input wire handshake_switch_i,
  input wire tx_permit_i,
  input wire [2:0] rate_sel_i,
  input wire cts_i,
  input wire dsr_i,
  input wire dcd_i,
  output reg rts_o,
  output reg dtr_o,
  output reg tx_char_start_en_o,
  output reg tx_hold_o,
  output reg rx_accept_o,
  output reg [2:0] rate_sel_o,
  output reg rate_refused_o,
  output reg connected_o
);

  // ----------------------------------------
  // synchronisers for modem status pins
  // ----------------------------------------
  reg [2:0] stat_meta_reg; // first stage, read only by second stage
  reg [2:0] stat_sync_reg; // {cts, dsr, dcd} safe to use

  // synchronised option straps, they are also pins
  reg [1:0] opt_meta_reg;
  reg [1:0] opt_sync_reg; // {half_duplex, handshake}

  // call state and answer timer
  reg [1:0] call_reg;
  reg [1:0] call_next;
  reg [31:0] timer_reg;
  reg [31:0] timer_next;

  wire cts_s;
  wire dsr_s;
  wire dcd_s;
  wire half_s;
  wire hs_on;
  wire cts_eff;
  wire dsr_eff;
  wire dcd_eff;
  wire timer_done;

  // call states, binary coded
  localparam [1:0] CALL_IDLE = 2'h0; // waiting for the modem to answer a ring
  localparam [1:0] CALL_WAIT_CARRIER = 2'h1; // answered, answer timer running
  localparam [1:0] CALL_CONNECTED = 2'h2; // carrier present, traffic allowed
  localparam [1:0] CALL_HANGUP = 2'h3; // terminal ready dropped to free the line

  // transmit path gate, shared by the start enable and the pause so they never disagree
  function tx_path_open;
    input cts_v;
    input dsr_v;
    input dcd_v;
    input half_v;
    begin
      tx_path_open = cts_v & dsr_v & (half_v | dcd_v);
    end
  endfunction

  // two flip-flops before any logic looks at a modem status or option strap pin
  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      stat_meta_reg <= 3'h0;
      stat_sync_reg <= 3'h0;
      opt_meta_reg <= 2'h0;
      opt_sync_reg <= 2'h0;
    end
    else
    begin
      stat_meta_reg <= {cts_i, dsr_i, dcd_i};
      stat_sync_reg <= stat_meta_reg;
      opt_meta_reg <= {half_duplex_i, handshake_switch_i};
      opt_sync_reg <= opt_meta_reg;
    end
  end

  assign cts_s = stat_sync_reg[2];
  assign dsr_s = stat_sync_reg[1];
  assign dcd_s = stat_sync_reg[0];
  assign half_s = opt_sync_reg[1];

  // ----------------------------------------
  // effective handshake view
  // ----------------------------------------
  // half duplex forces the handshake even with the switch off
  assign hs_on = opt_sync_reg[0] | half_s;
  // with the handshake off the pins read as permanently asserted
  assign cts_eff = hs_on ? cts_s : 1'b1;
  assign dsr_eff = hs_on ? dsr_s : 1'b1;
  // set ready starts a call and carrier marks it connected; handshake off reads carrier as present
  assign dcd_eff = hs_on ? dcd_s : 1'b1;

  assign timer_done = (timer_reg == 32'h0);

  // ----------------------------------------
  // call sequencing: answer, connected, hang-up
  // ----------------------------------------
  always @*
  begin
    call_next = call_reg;
    timer_next = timer_reg;
    if (timer_reg != 32'h0)
    begin
      timer_next = timer_reg - 32'h1;
    end
    case (call_reg)
      CALL_IDLE:
      begin
        // modem answered a ring: start waiting for carrier
        if (dsr_eff)
        begin
          call_next = CALL_WAIT_CARRIER;
          timer_next = ANSWER_TIMEOUT_CYCLES[31:0];
        end
      end
      CALL_WAIT_CARRIER:
      begin
        if (!dsr_eff)
        begin
          call_next = CALL_IDLE; // caller gave up first
        end
        else if (dcd_eff)
        begin
          call_next = CALL_CONNECTED;
        end
        else if (timer_done)
        begin
          call_next = CALL_HANGUP;
        end
      end
      CALL_CONNECTED:
      begin
        if (!dsr_eff)
        begin
          call_next = CALL_IDLE;
        end
        else if (!dcd_eff)
        begin
          // lost carrier gets a fresh full timeout to come back
          call_next = CALL_WAIT_CARRIER;
          timer_next = ANSWER_TIMEOUT_CYCLES[31:0];
        end
      end
      CALL_HANGUP:
      begin
        // stay on-hook request until the modem reports hang-up done
        if (!dsr_eff)
        begin
          call_next = CALL_IDLE;
        end
      end
      default:
      begin
        call_next = CALL_IDLE;
      end
    endcase
  end

  // state registers
  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      call_reg <= CALL_IDLE;
      timer_reg <= 32'h0;
    end
    else
    begin
      call_reg <= call_next;
      timer_reg <= timer_next;
    end
  end

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  // outputs lag their inputs by one cycle; dtr_o and connected_o decode call_next, so they change with the state, fine at serial bit rates
  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      rts_o <= 1'b0;
      dtr_o <= 1'b0;
      tx_char_start_en_o <= 1'b0;
      tx_hold_o <= 1'b1;
      rx_accept_o <= 1'b0;
      rate_sel_o <= 3'h0;
      rate_refused_o <= 1'b0;
      connected_o <= 1'b0;
    end
    else
    begin
      // full duplex holds it high, half duplex follows permission
      if (half_s)
      begin
        rts_o <= tx_permit_i;
      end
      else
      begin
        rts_o <= 1'b1;
      end
      // terminal ready drops only while hanging up
      dtr_o <= (call_next != CALL_HANGUP) | ~hs_on;
      // sending needs clear to send, set ready and, full duplex, carrier
      tx_char_start_en_o <= tx_path_open(cts_eff, dsr_eff, dcd_eff, half_s) &
                            (~half_s | tx_permit_i);
      // a character underway freezes whenever the same gate closes
      tx_hold_o <= ~tx_path_open(cts_eff, dsr_eff, dcd_eff, half_s);
      // receive only with set ready and carrier
      rx_accept_o <= dsr_eff & dcd_eff;
      // codes above the 9600 selection are clamped and flagged
      if (rate_sel_i > `RATE_SEL_MAX)
      begin
        rate_sel_o <= `RATE_SEL_MAX;
        rate_refused_o <= 1'b1;
      end
      else
      begin
        rate_sel_o <= rate_sel_i;
        rate_refused_o <= 1'b0;
      end
      connected_o <= (call_next == CALL_CONNECTED);
    end
  end

endmodule // modem_handshake_control

// file: tb/modem_handshake_props.sv
// Purpose: port checks of the handshake block
// Assumes: a pin reaches the outputs in 3 edges
// Notes: antecedents wait 4 steady cycles, except the rate check, which has none
`timescale 1ns/1ps
module modem_handshake_props(
  input wire clk_i, input wire reset_i,
  input wire half_duplex_i, input wire handshake_switch_i,
  input wire tx_permit_i, input wire [2:0] rate_sel_i,
  input wire cts_i, input wire dsr_i, input wire dcd_i,
  input wire rts_o, input wire dtr_o, input wire tx_char_start_en_o,
  input wire tx_hold_o, input wire rx_accept_o,
  input wire [2:0] rate_sel_o, input wire rate_refused_o,
  input wire connected_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // handshake in use while a modem pin is low
  sequence s_low(x); handshake_switch_i && !x; endsequence
  property p_rts_full; (!half_duplex_i)[*4] |=> rts_o; endproperty
  a_rts_full: assert property (p_rts_full) else $error("rts low");
  property p_rts_half; half_duplex_i[*4] |=> rts_o == $past(tx_permit_i); endproperty
  a_rts_half: assert property (p_rts_half) else $error("rts wrong");
  property p_dtr; (!half_duplex_i && !handshake_switch_i)[*4] |=> dtr_o; endproperty
  a_dtr: assert property (p_dtr) else $error("dtr low");
  property p_free; (!half_duplex_i && !handshake_switch_i)[*4] |=> rx_accept_o && !tx_hold_o; endproperty
  a_free: assert property (p_free) else $error("gated");
  property p_rate;
    1 |=> rate_refused_o == ($past(rate_sel_i) > 3'h6) &&
      rate_sel_o == (($past(rate_sel_i) > 3'h6) ? 3'h6 : $past(rate_sel_i));
  endproperty
  a_rate: assert property (p_rate) else $error("rate");
  property p_cts; s_low(cts_i)[*4] |=> !tx_char_start_en_o && tx_hold_o; endproperty
  a_cts: assert property (p_cts) else $error("sent");
  property p_dsr; s_low(dsr_i)[*4] |=> !tx_char_start_en_o && !rx_accept_o; endproperty
  a_dsr: assert property (p_dsr) else $error("dsr");
  property p_dcd; s_low(dcd_i)[*4] |=> !rx_accept_o; endproperty
  a_dcd: assert property (p_dcd) else $error("dcd");
  property p_fdx; (!half_duplex_i && handshake_switch_i && !dcd_i)[*4] |=> !tx_char_start_en_o; endproperty
  a_fdx: assert property (p_fdx) else $error("fdx");
endmodule // modem_handshake_props

// file: tb/modem_partner.sv
// Purpose: behavioural modem on the pins
// Assumes: answers while ringing and dtr high
// Notes: dropping dtr hangs up at once
`timescale 1ns/1ps
module modem_partner(
  input wire clk_i,
  input wire dtr_i,
  input wire ring_i, // call ringing
  input wire carrier_i, // remote carrier
  input wire clear_i, // ready to send
  output reg dsr_o,
  output reg dcd_o,
  output reg cts_o
);
  // off-hook only while ringing and dtr high
  always @(posedge clk_i)
  begin
    dsr_o <= ring_i & dtr_i;
    dcd_o <= ring_i & dtr_i & carrier_i;
    cts_o <= ring_i & dtr_i & clear_i;
  end
endmodule // modem_partner

// file: tb/modem_handshake_control_test.sv
// Purpose: self-checking bench
// Assumes: answer timer cut to 20 cycles
// Notes: modem model answers calls
`timescale 1ns/1ps
module modem_handshake_control_test;
  reg clk_i = 1'b0, reset_i = 1'b1, half_duplex_i = 1'b0;
  reg handshake_switch_i = 1'b0, tx_permit_i = 1'b0;
  reg [2:0] rate_sel_i = 3'h0;
  reg ring = 1'b0, carrier = 1'b0, clear = 1'b0; // modem controls
  wire cts_i, dsr_i, dcd_i, rts_o, dtr_o, tx_char_start_en_o, tx_hold_o;
  wire rx_accept_o, rate_refused_o, connected_o;
  wire [2:0] rate_sel_o;
  integer num_errors = 0, n_compared = 0, i, j;
  initial forever #4 clk_i = ~clk_i;
  modem_handshake_control #(.ANSWER_TIMEOUT_CYCLES(20)) dut(.clk_i(clk_i), .reset_i(reset_i),
    .half_duplex_i(half_duplex_i), .handshake_switch_i(handshake_switch_i), .tx_permit_i(tx_permit_i),
    .rate_sel_i(rate_sel_i), .cts_i(cts_i), .dsr_i(dsr_i), .dcd_i(dcd_i), .rts_o(rts_o), .dtr_o(dtr_o),
    .tx_char_start_en_o(tx_char_start_en_o), .tx_hold_o(tx_hold_o), .rx_accept_o(rx_accept_o),
    .rate_sel_o(rate_sel_o), .rate_refused_o(rate_refused_o), .connected_o(connected_o));
  modem_partner modem(.clk_i(clk_i), .dtr_i(dtr_o), .ring_i(ring), .carrier_i(carrier),
    .clear_i(clear), .dsr_o(dsr_i), .dcd_o(dcd_i), .cts_o(cts_i));
  // compare outputs, sampled 1 ns after an edge
  task chk(input [4:0] got, input [4:0] exp);
  begin
    n_compared = n_compared + 1;
    if (got !== exp)
    begin
      num_errors = num_errors + 1;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  end
  endtask
  task cyc(input integer n);
  begin
    repeat (n) @(posedge clk_i);
    #1;
  end
  endtask
  // bounded wait on dtr; a hang ends the run
  task wdtr(input v);
  begin
    for (i = 0; i < 60 && dtr_o !== v; i = i + 1)
      cyc(1);
    chk(dtr_o, v);
    if (dtr_o !== v)
      give_verdict;
  end
  endtask
  task give_verdict;
  begin
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask
  // handshake off: every rate code, pins ignored
  task t_free;
  begin
    for (j = 0; j < 8; j = j + 1)
    begin
      @(posedge clk_i);
      rate_sel_i <= j[2:0];
      cyc(2);
      chk({rate_refused_o, rate_sel_o}, (j > 6) ? 5'he : j[4:0]);
    end
    chk({rts_o, dtr_o, rx_accept_o, tx_char_start_en_o, tx_hold_o}, 5'h1e);
    $display("free done");
  end
  endtask
  // answered call, cts loss, carrier loss, hang-up
  task t_call;
  begin
    @(posedge clk_i);
    handshake_switch_i <= 1'b1;
    ring <= 1'b1;
    clear <= 1'b1;
    cyc(8);
    chk({dtr_o, connected_o, rx_accept_o}, 5'h4);
    carrier <= 1'b1;
    cyc(6);
    chk({connected_o, rx_accept_o, tx_char_start_en_o, tx_hold_o}, 5'he);
    clear <= 1'b0;
    cyc(6);
    chk({tx_char_start_en_o, tx_hold_o}, 5'h1);
    clear <= 1'b1;
    carrier <= 1'b0;
    cyc(6);
    chk({rx_accept_o, tx_char_start_en_o, dtr_o}, 5'h1);
    cyc(15);
    chk(dtr_o, 1'b1);
    wdtr(1'b0);
    ring <= 1'b0;
    wdtr(1'b1);
    // a second call that never brings carrier must time out too
    ring <= 1'b1;
    cyc(10);
    chk({dtr_o, connected_o}, 5'h2);
    wdtr(1'b0);
    ring <= 1'b0;
    wdtr(1'b1);
    $display("call done");
  end
  endtask
  // half duplex uses the pins with switch off
  task t_half;
  begin
    @(posedge clk_i);
    handshake_switch_i <= 1'b0;
    half_duplex_i <= 1'b1;
    cyc(6);
    chk({rts_o, tx_hold_o}, 5'h1);
    @(posedge clk_i);
    tx_permit_i <= 1'b1;
    cyc(2);
    chk(rts_o, 1'b1);
    // answered line without carrier: half duplex may still send
    ring <= 1'b1;
    cyc(5);
    chk({tx_char_start_en_o, rx_accept_o, tx_hold_o}, 5'h4);
    @(posedge clk_i);
    tx_permit_i <= 1'b0;
    cyc(2);
    chk({rts_o, tx_char_start_en_o, tx_hold_o}, 5'h0);
    ring <= 1'b0;
    $display("half done");
  end
  endtask
  initial
  begin
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    cyc(6);
    t_free;
    t_call;
    t_half;
    give_verdict;
  end
endmodule // modem_handshake_control_test
bind modem_handshake_control modem_handshake_props props(.clk_i(clk_i), .reset_i(reset_i),
  .half_duplex_i(half_duplex_i), .handshake_switch_i(handshake_switch_i), .tx_permit_i(tx_permit_i),
  .rate_sel_i(rate_sel_i), .cts_i(cts_i), .dsr_i(dsr_i), .dcd_i(dcd_i), .rts_o(rts_o), .dtr_o(dtr_o),
  .tx_char_start_en_o(tx_char_start_en_o), .tx_hold_o(tx_hold_o), .rx_accept_o(rx_accept_o),
  .rate_sel_o(rate_sel_o), .rate_refused_o(rate_refused_o), .connected_o(connected_o));
